// ### hdl/ftx_code_path.sv
// Purpose: 100 Mb/s transmit coding path, nibbles to mlt-3 streams
// Assumes: mac inputs synchronous, new nibble due after each request
// Notes: one line bit every two clocks, five bits per code-group
//
// Contract
// - every mac nibble becomes a 5-bit group
// - first two preamble nibbles become J then K
// - enable drop inserts T then R
// - idle groups fill gaps until next frame
// - serial stream xored with 11-bit lfsr
// - scrambler seed derived from phy address straps
// - scrambler can be bypassed
// - nrzi encode after scrambling
// - two streams with alternating one events
// - nrzi and mlt-3 outputs both driven, no mode select
// - line stream runs at 125 Mb/s
// - standard idle, start, data, end sequencing
// - idle, T and R decode to 0000
// - J and K decode to 0101, halt errors
// - control group in data raises error
`timescale 1ns/1ps
`default_nettype none
module ftx_code_path
  import ftx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic tx_en_i,
  input wire logic tx_er_i,
  input wire logic [ftx_pkg::NIBBLE_W-1:0] txd_i,
  input wire logic [ftx_pkg::ADDR_W-1:0] phy_address_straps_i,
  input wire logic scrambler_bypass_i,
  input wire logic [ftx_pkg::GROUP_W-1:0] check_group_i,
  input wire logic check_in_data_i,
  output logic tx_nibble_req_o,
  output logic nrzi_o,
  output logic line_pos_o,
  output logic line_neg_o,
  output logic [ftx_pkg::NIBBLE_W-1:0] check_nibble_o,
  output logic check_error_o
);
  import ftx_pkg::*;

  typedef struct packed {
    ftx_state_type fsm;
    logic [DIV_W-1:0] div;
    logic [2:0] bit_cnt;
    logic [GROUP_W-1:0] shreg;
    logic [LFSR_W-1:0] lfsr;
    logic nrzi;
    logic [1:0] phase;
    logic pos;
    logic neg;
    logic req;
  } ftx_core_type;

  ftx_core_type st;
  ftx_core_type next_st;

  logic bit_tick;
  logic load;
  logic plain_bit;
  logic scr_bit;
  logic line_bit;
  logic feedback;
  logic [LFSR_W-1:0] seed;
  logic [GROUP_W-1:0] next_group;

  assign bit_tick = (st.div == DIV_LAST);
  assign load = bit_tick && (st.bit_cnt == BIT_LAST);
  assign plain_bit = st.shreg[GROUP_W-1];
  assign seed = {SEED_UPPER, phy_address_straps_i};

  always_comb begin
    // tap feedback of x^11 + x^9 + 1
    feedback = st.lfsr[TAP_HI] ^ st.lfsr[TAP_LO];
    scr_bit = plain_bit ^ st.lfsr[TAP_HI];
    line_bit = scrambler_bypass_i ? plain_bit : scr_bit;
  end

  // group chosen at each symbol boundary
  always_comb begin
    next_group = CG_IDLE;
    unique case (st.fsm)
      st_idle: begin
        if (tx_en_i) begin
          next_group = CG_J;
        end
      end
      st_send_k: begin
        next_group = CG_K;
      end
      st_data: begin
        if (!tx_en_i) begin
          next_group = CG_T;
        end else if (tx_er_i) begin
          next_group = CG_HALT;
        end else begin
          next_group = ftx_encode(txd_i);
        end
      end
      st_send_r: begin
        next_group = CG_R;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.req = 1'b0;
    next_st.div = (bit_tick) ? DIV_ZERO : DIV_W'(st.div + 1'b1);
    if (bit_tick) begin
      next_st.lfsr = {st.lfsr[LFSR_W-2:0], feedback};
      // lockup guard keeps the register live
      if ({st.lfsr[LFSR_W-2:0], feedback} == LFSR_ZERO) begin
        next_st.lfsr = seed;
      end
      // transition on a one
      next_st.nrzi = st.nrzi ^ line_bit;
      // each one advances the 0,+,0,- cycle
      if (line_bit) begin
        next_st.phase = 2'(st.phase + 1'b1);
      end
      next_st.pos = (next_st.phase == PH_POS);
      next_st.neg = (next_st.phase == PH_NEG);
      if (load) begin
        next_st.bit_cnt = BIT_FIRST;
        next_st.shreg = next_group;
        next_st.req = 1'b1;
        unique case (st.fsm)
          st_idle: begin
            if (tx_en_i) begin
              next_st.fsm = st_send_k;
            end
          end
          st_send_k: begin
            next_st.fsm = st_data;
          end
          st_data: begin
            if (!tx_en_i) begin
              next_st.fsm = st_send_r;
            end
          end
          st_send_r: begin
            next_st.fsm = st_idle;
          end
        endcase
      end else begin
        next_st.bit_cnt = 3'(st.bit_cnt + 1'b1);
        next_st.shreg = {st.shreg[GROUP_W-2:0], 1'b0};
      end
    end
    if (!rst_b_i) begin
      next_st = '0;
      next_st.fsm = st_idle;
      next_st.shreg = CG_IDLE;
      next_st.phase = PH_ZERO;
      next_st.lfsr = seed;
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  assign tx_nibble_req_o = st.req;
  assign nrzi_o = st.nrzi;
  assign line_pos_o = st.pos;
  assign line_neg_o = st.neg;

  ftx_group_decode u_decode (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .group_i(check_group_i),
    .in_data_i(check_in_data_i),
    .nibble_o(check_nibble_o),
    .error_o(check_error_o)
  );

  a_bit_rate: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick |=> !bit_tick ##1 bit_tick)
    else $error("line bit not every second clock");

  a_req_spacing: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    tx_nibble_req_o |=> !tx_nibble_req_o [*8] ##1 !tx_nibble_req_o
    ##1 tx_nibble_req_o)
    else $error("nibble request not every ten clocks");

  a_start_j: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_idle && tx_en_i |=> st.shreg == CG_J
    ##10 st.shreg == CG_K)
    else $error("start pair J K not sent");

  a_end_t: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_data && !tx_en_i |=> st.shreg == CG_T
    ##10 st.shreg == CG_R
    ##10 st.shreg == ($past(tx_en_i) ? CG_J : CG_IDLE))
    else $error("end pair T R or idle missing");

  a_idle_fill: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_idle && !tx_en_i |=> st.shreg == CG_IDLE)
    else $error("idle not sent between frames");

  a_data_group: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_data && tx_en_i && !tx_er_i
    |=> st.shreg == ftx_encode($past(txd_i)))
    else $error("data nibble encoded wrongly");

  a_lfsr_live: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.lfsr != LFSR_ZERO)
    else $error("scrambler reached all zero");

  a_lfsr_step: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && st.lfsr != LFSR_ZERO |=> st.lfsr ==
    {$past(st.lfsr[LFSR_W-2:0]),
    $past(st.lfsr[TAP_HI]) ^ $past(st.lfsr[TAP_LO])})
    else $error("scrambler step wrong");

  a_bypass_pass: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && scrambler_bypass_i && plain_bit |=> nrzi_o != $past(nrzi_o))
    else $error("bypass one did not toggle line");

  a_nrzi_hold: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !bit_tick |=> $stable(nrzi_o) && $stable(line_pos_o))
    else $error("line changed between bit times");

  a_mlt_alt: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !(line_pos_o && line_neg_o) && (!line_pos_o || st.phase == PH_POS))
    else $error("mlt-3 streams overlap");

  a_reset_idle: assert property (
    @(posedge clock_i) !rst_b_i |=> st.fsm == st_idle && !tx_nibble_req_o
    && !nrzi_o && !line_pos_o && !line_neg_o)
    else $error("reset did not clear transmit state");

  a_seed_straps: assert property (
    @(posedge clock_i) !rst_b_i |=>
    st.lfsr == {SEED_UPPER, $past(phy_address_straps_i)})
    else $error("scrambler seed not taken from straps");

  a_k_then_data: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_send_k |=> st.fsm == st_data && st.shreg == CG_K)
    else $error("K group not followed by data state");

  a_r_then_idle: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_send_r |=> st.fsm == st_idle && st.shreg == CG_R)
    else $error("R group not followed by idle state");

  a_data_stay: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load && st.fsm == st_data && tx_en_i |=> st.fsm == st_data)
    else $error("data state left while enable high");

  a_req_on_load: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    load |=> tx_nibble_req_o)
    else $error("nibble request missing after load");

  a_req_only_load: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !load |=> !tx_nibble_req_o)
    else $error("nibble request without load");

  a_shift_msb_first: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && !load |=> st.shreg == {$past(st.shreg[GROUP_W-2:0]), 1'b0})
    else $error("group not shifted msb first");

  a_bit_count: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.bit_cnt <= BIT_LAST)
    else $error("more than five bits in a group");

  a_nrzi_one: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && line_bit |=> nrzi_o != $past(nrzi_o))
    else $error("one bit did not toggle nrzi");

  a_nrzi_zero: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && !line_bit |=> $stable(nrzi_o))
    else $error("zero bit toggled nrzi");

  a_scramble_xor: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && !scrambler_bypass_i |=> (nrzi_o != $past(nrzi_o))
    == $past(plain_bit ^ st.lfsr[TAP_HI]))
    else $error("scrambled bit did not drive line");

  a_bypass_zero: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && scrambler_bypass_i && !plain_bit |=> $stable(nrzi_o))
    else $error("bypass zero toggled line");

  a_mlt_via_zero: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(line_pos_o) || $fell(line_neg_o) |-> !line_pos_o && !line_neg_o)
    else $error("mlt-3 skipped the zero level");

  a_mlt_zero_hold: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && !line_bit |=> $stable(line_pos_o) && $stable(line_neg_o))
    else $error("mlt-3 level moved on a zero");

  a_mlt_step: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bit_tick && line_bit |=> $changed(line_pos_o) || $changed(line_neg_o))
    else $error("mlt-3 level held on a one");

endmodule
`default_nettype wire

// ### hdl/ftx_pkg.sv
// Purpose: shared constants, types and code-group table helpers
// Assumes: one 250 MHz clock, line bit rate 125 Mb/s
// Notes: code-groups listed msb first, msb leaves the line first
package ftx_pkg;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int LINE_MBPS = 125;
  localparam int CLK_PER_BIT = CLK_MHZ / LINE_MBPS;
  localparam int DIV_W = 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_BIT - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // symbol framing
  localparam int GROUP_W = 5;
  localparam int NIBBLE_W = 4;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h4;

  // scrambler
  localparam int LFSR_W = 11;
  localparam int TAP_HI = 10;
  localparam int TAP_LO = 8;
  localparam int ADDR_W = 5;
  // upper seed bits, arbitrary non-zero filler
  localparam logic [5:0] SEED_UPPER = 6'h2B;
  localparam logic [10:0] LFSR_ZERO = 11'h000;

  // control code-groups
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;

  // decode meanings of control groups
  localparam logic [3:0] NIB_IDLE_END = 4'h0;
  localparam logic [3:0] NIB_START = 4'h5;
  localparam logic [3:0] NIB_NONE = 4'h0;

  // mlt-3 phase codes
  localparam logic [1:0] PH_POS = 2'h1;
  localparam logic [1:0] PH_NEG = 2'h3;
  localparam logic [1:0] PH_ZERO = 2'h0;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_send_k = 2'b01,
    st_data = 2'b10,
    st_send_r = 2'b11
  } ftx_state_type;

  // data nibble to code-group
  function automatic logic [4:0] ftx_encode(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1E;
    unique case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      4'hF: cg = 5'h1D;
    endcase
    return cg;
  endfunction

  // code-group to {invalid, control, nibble}
  function automatic logic [5:0] ftx_decode(input logic [4:0] cg);
    logic [5:0] r;
    r = {1'b1, 1'b0, NIB_NONE};
    for (int n = 0; n < 16; n++) begin
      if (ftx_encode(4'(n)) == cg) begin
        r = {1'b0, 1'b0, 4'(n)};
      end
    end
    if (cg == CG_IDLE || cg == CG_T || cg == CG_R) begin
      r = {1'b0, 1'b1, NIB_IDLE_END};
    end
    if (cg == CG_J || cg == CG_K) begin
      r = {1'b0, 1'b1, NIB_START};
    end
    return r;
  endfunction

endpackage

// ### hdl/ftx_group_decode.sv
// Purpose: registered code-group to nibble lookup with error flag
// Assumes: group and data-field flag valid on the sampling edge
// Notes: one cycle latency
`timescale 1ns/1ps
`default_nettype none
module ftx_group_decode
  import ftx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [ftx_pkg::GROUP_W-1:0] group_i,
  input wire logic in_data_i,
  output logic [ftx_pkg::NIBBLE_W-1:0] nibble_o,
  output logic error_o
);
  import ftx_pkg::*;

  typedef struct packed {
    logic [3:0] nibble;
    logic error;
  } ftx_dec_type;

  ftx_dec_type st;
  ftx_dec_type next_st;
  logic [5:0] look;

  always_comb begin
    look = ftx_decode(group_i);
    next_st.nibble = look[3:0];
    // halt and unknown groups flag error
    next_st.error = look[5];
    // control group inside data field
    if (in_data_i && look[4]) begin
      next_st.error = 1'b1;
      next_st.nibble = NIB_NONE;
    end
    if (!rst_b_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  assign nibble_o = st.nibble;
  assign error_o = st.error;

  a_ctl_in_data: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    in_data_i && (group_i == CG_J || group_i == CG_T) |=> error_o)
    else $error("control group in data not flagged");

  a_start_nibble: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !in_data_i && group_i == CG_K |=> nibble_o == NIB_START && !error_o)
    else $error("start group did not decode to 0101");

  a_idle_nibble: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !in_data_i && group_i == CG_R |=> nibble_o == NIB_IDLE_END)
    else $error("end group did not decode to 0000");

endmodule
`default_nettype wire

// ### verification/ftx_mac_model.sv
// Purpose: mac side model, hands a nibble after each take
// Assumes: request pulse follows every load edge
// Notes: data lines carry noise while enable is low
`timescale 1ns/1ps
`default_nettype none
module ftx_mac_model (
  input wire logic clock_i,
  input wire logic req_i,
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  logic [4:0] q[$];
  task automatic push(input logic en, input logic [3:0] nib);
    q.push_back({en, nib});
  endtask
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  end
  // next nibble presented right after a take
  always @(negedge clock_i) begin
    if (req_i) begin
      if (q.size() > 0) begin
        {tx_en_o, txd_o} = q.pop_front();
      end else begin
        tx_en_o = 1'b0;
        txd_o = ~txd_o;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/test_fast_ethernet_tx_code_path.sv
// Purpose: self-checking bench for the transmit coding path
// Assumes: line bits recovered from nrzi every two clocks
// Notes: random frames from a fixed seed plus an ordered frame
`timescale 1ns/1ps
`default_nettype none
module test_fast_ethernet_tx_code_path;
  import ftx_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic byp = 1'b0;
  logic cin = 1'b0;
  logic [4:0] cg = 5'h00;
  logic [4:0] straps = 5'h00;
  logic [3:0] txd, cnib;
  logic tx_en, req, nrzi, pos, neg, cerr, pn;
  logic [1:0] ph;
  int seed = 14;
  int n_errors = 0;
  int samples_checked = 0;
  int cnt = 0;
  int lastreq = 0;
  logic bits[$];
  logic [4:0] exq[$];
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
    5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
    5'h1A, 5'h1B, 5'h1C, 5'h1D};
  always #2 clock_i = ~clock_i;
  ftx_mac_model i_mac (.clock_i(clock_i), .req_i(req),
    .tx_en_o(tx_en), .txd_o(txd));
  ftx_code_path i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .tx_en_i(tx_en), .tx_er_i(1'b0), .txd_i(txd),
    .phy_address_straps_i(straps), .scrambler_bypass_i(byp),
    .check_group_i(cg), .check_in_data_i(cin),
    .tx_nibble_req_o(req), .nrzi_o(nrzi), .line_pos_o(pos),
    .line_neg_o(neg), .check_nibble_o(cnib), .check_error_o(cerr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [4:0] grp(input int i);
    return {bits[i], bits[i+1], bits[i+2], bits[i+3], bits[i+4]};
  endfunction
  // expected {error, nibble}
  function automatic logic [4:0] dec(input logic [4:0] g, input logic d);
    dec = 5'h10;
    for (int n = 0; n < 16; n++) if (ENC[n] == g) dec = 5'(n);
    if (!d && (g == CG_IDLE || g == CG_T || g == CG_R)) dec = 5'(NIB_IDLE_END);
    if (!d && (g == CG_J || g == CG_K)) dec = 5'(NIB_START);
  endfunction
  task automatic frame(input int len, input int gap, input bit ord);
    logic [3:0] d;
    i_mac.push(1'b1, 4'h5);
    i_mac.push(1'b1, 4'h5);
    exq.push_back(CG_J);
    exq.push_back(CG_K);
    for (int k = 0; k < len; k++) begin
      d = ord ? 4'(k) : 4'($random(seed));
      i_mac.push(1'b1, d);
      exq.push_back(ENC[d]);
    end
    exq.push_back(CG_T);
    exq.push_back(CG_R);
    for (int k = 0; k < gap + 2; k++) i_mac.push(1'b0, 4'($random(seed)));
    for (int k = 0; k < gap; k++) exq.push_back(CG_IDLE);
  endtask
  always @(posedge clock_i) cnt <= rst_b_i ? cnt + 1 : 0;
  always @(negedge clock_i) begin
    if (rst_b_i && cnt >= 2 && cnt[0] == 1'b0) begin
      bits.push_back(nrzi ^ pn);
      if (nrzi ^ pn) ph = ph + 2'h1;
      chk({pos, neg}, {ph == PH_POS, ph == PH_NEG});
      pn = nrzi;
    end
    if (rst_b_i && req) begin
      if (lastreq > 0) chk(16'(cnt - lastreq), 16'h000A);
      lastreq = cnt;
    end
    if (!rst_b_i) begin
      pn = 1'b0;
      ph = PH_ZERO;
      lastreq = 0;
    end
  end
  initial begin
    logic [10:0] s;
    int i;
    straps = 5'($random(seed));
    s = {SEED_UPPER, straps};
    repeat (8) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (60) @(negedge clock_i);
    for (int k = 0; k < 11; k++) chk(bits[k], !s[10-k]);
    for (int k = 0; k + 11 < bits.size(); k++) begin
      chk(bits[k+11], !(bits[k] ^ bits[k+2]));
    end
    for (int k = 0; k < 64; k++) begin
      cg = 5'(k);
      cin = k[5];
      @(negedge clock_i);
      chk(cerr ? 5'h10 : {1'b0, cnib}, dec(cg, cin));
    end
    byp = 1'b1;
    bits.delete();
    frame(16, 0, 1'b1);
    repeat (3) frame(1 + ($random(seed) & 7), $random(seed) & 3, 1'b0);
    exq.push_back(CG_IDLE);
    exq.push_back(CG_IDLE);
    repeat (900) @(negedge clock_i);
    for (i = 0; i + 10 < bits.size(); i++) begin
      if (grp(i) == CG_J && grp(i + 5) == CG_K) break;
    end
    foreach (exq[k]) chk(grp(i + 5 * k), exq[k]);
    print_verdict();
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
